// >>> rtl/tmr2cc_cfg.svh
// Register indices, field positions and reset values of the timer block.
`ifndef TMR2CC_CFG_SVH
`define TMR2CC_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TMR2CC_IDX_HIGH_VALUE   6'h01
`define TMR2CC_IDX_HIGH_RELOAD  6'h02
`define TMR2CC_IDX_HIGH_CC      6'h03
`define TMR2CC_IDX_FLAGS_B      6'h0b
`define TMR2CC_IDX_VALUE        6'h0c
`define TMR2CC_IDX_RELOAD       6'h0d
`define TMR2CC_IDX_CC           6'h0e
`define TMR2CC_IDX_CONFIG       6'h0f
`define TMR2CC_IDX_CONTROL_A    6'h10

// ----------------------------------------------------------------------
// Flags/control B fields
// ----------------------------------------------------------------------
`define TMR2CC_B_LOW_CMP        0
`define TMR2CC_B_CC             1
`define TMR2CC_B_LOW_OVF        2
`define TMR2CC_B_MAIN_OVF       3
`define TMR2CC_B_SEC_POL        5
`define TMR2CC_B_SEC_OE         6
`define TMR2CC_B_LOW_IE         7
`define TMR2CC_B_FLAG_MASK      8'h0f
`define TMR2CC_B_RW_MASK        8'he0

// ----------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------
`define TMR2CC_CFG_CT           0
`define TMR2CC_CFG_EDGE_LO      1
`define TMR2CC_CFG_SPLIT        3
`define TMR2CC_CFG_DIV_LO       4

// ----------------------------------------------------------------------
// Control A fields
// ----------------------------------------------------------------------
`define TMR2CC_A_CAP_RELOAD     2
`define TMR2CC_A_RUN            3
`define TMR2CC_A_LOW_RUN        4
`define TMR2CC_A_PRI_POL        5
`define TMR2CC_A_PRI_OE         6
`define TMR2CC_A_MAIN_IE        7
`define TMR2CC_A_RW_MASK        8'hfc

// ----------------------------------------------------------------------
// Reset values and edge codes
// ----------------------------------------------------------------------
`define TMR2CC_RST_BYTE         8'h00
`define TMR2CC_RST_WORD         16'h0000
`define TMR2CC_EDGE_NONE        2'h0
`define TMR2CC_EDGE_RISE        2'h1
`define TMR2CC_EDGE_FALL        2'h2
`define TMR2CC_EDGE_BOTH        2'h3

`endif

// >>> rtl/tmr2cc_pkg.sv
// Types shared by the timer block and its input synchroniser.
package tmr2cc_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tmr2cc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } tmr2cc_apb_rsp_t;

    typedef struct packed {
        logic first;
        logic second;
        logic prev;
        logic rise;
        logic fall;
    } tmr2cc_sync_state_t;

    typedef struct packed {
        tmr2cc_apb_rsp_t rsp;
        logic [15:0]     cnt;
        logic [15:0]     rld;
        logic [15:0]     cc;
        logic [7:0]      cfg;
        logic [7:0]      cnb;
        logic [7:0]      cna;
        logic [6:0]      presc;
        logic            wave_a;
        logic            wave_b;
        logic            oe0_prev;
        logic            oe1_prev;
        logic            pin_p;
        logic            pin_b;
        logic            irq_main;
        logic            irq_low;
    } tmr2cc_state_t;

endpackage

// >>> rtl/tmr2cc_sync.sv
// Two-stage synchroniser with registered edge pulses for the edge input.
`timescale 1ns/1ps
`default_nettype none
module tmr2cc_sync (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      rise,
    output logic      fall
);
    tmr2cc_pkg::tmr2cc_sync_state_t s_q;
    tmr2cc_pkg::tmr2cc_sync_state_t s_d;

    // Only the second stage feeds the edge compare.
    always_comb begin
        s_d        = s_q;
        s_d.first  = async_in;
        s_d.second = s_q.first;
        s_d.prev   = s_q.second;
        s_d.rise   = s_q.second & ~s_q.prev;
        s_d.fall   = ~s_q.second & s_q.prev;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rise = s_q.rise;
    assign fall = s_q.fall;
endmodule
`default_nettype wire

// >>> rtl/tmr2cc_top.sv
// Timer with capture, reload and compare, split mode and APB registers.
//
// Contract
// R1 - Split mode: low timer matching low compare byte sets low compare flag.
// R2 - Compare match (16-bit or high byte) or capture sets capture flag.
// R3 - Split mode: low byte timer overflow sets low overflow flag.
// R4 - Full overflow, or high byte overflow in split mode, sets main flag.
// R5 - Secondary polarity gives alternate pin start level; source per mode.
// R6 - Secondary polarity reaches pin only when its enable rises.
// R7 - Low interrupt enable gates low overflow and low compare requests.
// R8 - Split mode: value, reload, compare read high byte 00, ignore writes.
// R9 - Value register holds live count; writing it changes the count.
// R10 - Reload register holds the value loaded on a reload event.
// R11 - Compare register holds match value, or captured count on capture.
// R12 - Select bit picks timer (0) or edge counting (1) for main timer.
// R13 - Edge field: none compares or disables; rise/fall capture or count.
// R14 - The low byte timer always works in compare mode in split mode.
// R15 - Split select: 0 one 16-bit timer, 1 two 8-bit timers.
// R16 - Timer mode clock divides by two to the power of the divide field.
// R17 - Output enables route waveforms per mode; disabled pin shows latch.
// R18 - Run enable low stops the timer and keeps the count.
// R19 - Flags stay set until software writes zero; set beats clear.
// R20 - Compare mode counts up and loads reload value on each overflow.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tmr2cc_cfg.svh"
module tmr2cc_top (
    input  wire logic                         mclk,
    input  wire logic                         reset,
    input  wire tmr2cc_pkg::tmr2cc_apb_req_t  apb_req,
    output tmr2cc_pkg::tmr2cc_apb_rsp_t       apb_rsp,
    input  wire logic                         edge_input,
    input  wire logic                         primary_port_latch,
    input  wire logic                         alternate_port_latch,
    output logic                              primary_output_pin,
    output logic                              alternate_output_pin,
    output logic                              main_irq,
    output logic                              low_irq
);
    tmr2cc_pkg::tmr2cc_state_t s_q;
    tmr2cc_pkg::tmr2cc_state_t s_d;

    logic        edge_rise;
    logic        edge_fall;
    logic        access;
    logic        first_cyc;
    logic        wr;
    logic        hit;
    logic [5:0]  idx;
    logic [31:0] wdata;
    logic [31:0] rd;
    logic        split;
    logic        ct_sel;
    logic [1:0]  edge_sel;
    logic [2:0]  div_sel;
    logic [6:0]  div_mask;
    logic        presc_tick;
    logic        edge_hit;
    logic        cap_mode;
    logic        run;
    logic        main_step;
    logic        low_step;
    logic        hi_ovf;
    logic        hi_match;
    logic        lo_ovf;
    logic        lo_match;
    logic        capture;
    logic [15:0] cnt_full;
    logic [7:0]  cnt_hi;
    logic [7:0]  cnt_lo;

    // ------------------------------------------------------------------
    // Edge input synchroniser
    // ------------------------------------------------------------------
    tmr2cc_sync u_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in (edge_input),
        .rise     (edge_rise),
        .fall     (edge_fall)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        idx      = apb_req.paddr[7:2];
        wdata    = apb_req.pwdata;
        access   = apb_req.psel & apb_req.penable;
        first_cyc = access & ~s_q.rsp.pready;
        wr       = access & s_q.rsp.pready & apb_req.pwrite;
        split    = s_q.cfg[`TMR2CC_CFG_SPLIT]; // R15
        ct_sel   = s_q.cfg[`TMR2CC_CFG_CT];
        edge_sel = s_q.cfg[`TMR2CC_CFG_EDGE_LO +: 2];
        div_sel  = s_q.cfg[`TMR2CC_CFG_DIV_LO +: 3];
        run      = s_q.cna[`TMR2CC_A_RUN];

        // Register read decode.
        hit = 1'b1;
        rd  = '0;
        unique case (idx)
            `TMR2CC_IDX_HIGH_VALUE:  rd[7:0] = s_q.cnt[15:8];
            `TMR2CC_IDX_HIGH_RELOAD: rd[7:0] = s_q.rld[15:8];
            `TMR2CC_IDX_HIGH_CC:     rd[7:0] = s_q.cc[15:8];
            `TMR2CC_IDX_FLAGS_B: begin
                rd[7:0] = s_q.cnb & (`TMR2CC_B_RW_MASK | `TMR2CC_B_FLAG_MASK);
            end
            `TMR2CC_IDX_VALUE: begin
                rd[15:0] = split ? {8'h00, s_q.cnt[7:0]} : s_q.cnt; // R8 R9
            end
            `TMR2CC_IDX_RELOAD: begin
                rd[15:0] = split ? {8'h00, s_q.rld[7:0]} : s_q.rld; // R8
            end
            `TMR2CC_IDX_CC: begin
                rd[15:0] = split ? {8'h00, s_q.cc[7:0]} : s_q.cc; // R8
            end
            `TMR2CC_IDX_CONFIG:    rd[7:0] = s_q.cfg;
            `TMR2CC_IDX_CONTROL_A: rd[7:0] = s_q.cna & `TMR2CC_A_RW_MASK;
            default:               hit = 1'b0;
        endcase

        // APB answer one cycle into the access phase.
        s_d.rsp.pready  = first_cyc;
        s_d.rsp.pslverr = first_cyc & ~hit;
        s_d.rsp.prdata  = (first_cyc & ~apb_req.pwrite) ? rd : '0;

        // Prescaler, tick once every 2^div clocks.
        s_d.presc  = 7'(s_q.presc + 7'h01);
        div_mask   = 7'((8'h01 << div_sel) - 8'h01);
        presc_tick = (s_q.presc & div_mask) == div_mask; // R16

        // Main timer stepping and capture.
        unique case (edge_sel)
            `TMR2CC_EDGE_RISE: edge_hit = edge_rise;
            `TMR2CC_EDGE_FALL: edge_hit = edge_fall;
            `TMR2CC_EDGE_BOTH: edge_hit = edge_rise | edge_fall;
            `TMR2CC_EDGE_NONE: edge_hit = 1'b0;
        endcase
        cap_mode  = ~ct_sel & (edge_sel != `TMR2CC_EDGE_NONE); // R13
        main_step = run & (ct_sel ? edge_hit : presc_tick); // R12 R13 R18
        low_step  = split & s_q.cna[`TMR2CC_A_LOW_RUN] & presc_tick; // R14
        capture   = run & cap_mode & edge_hit; // R11

        // Work out the next counts.
        cnt_full = s_q.cnt;
        cnt_hi   = s_q.cnt[15:8];
        cnt_lo   = s_q.cnt[7:0];
        hi_ovf   = 1'b0;
        hi_match = 1'b0;
        lo_ovf   = 1'b0;
        lo_match = 1'b0;
        if (main_step) begin
            if (!split) begin
                hi_ovf   = s_q.cnt == 16'hffff; // R4
                cnt_full = hi_ovf ? s_q.rld : 16'(s_q.cnt + 16'h0001); // R20
                hi_match = ~cap_mode & (cnt_full == s_q.cc); // R2
                cnt_hi   = cnt_full[15:8];
                cnt_lo   = cnt_full[7:0];
            end else begin
                hi_ovf   = s_q.cnt[15:8] == 8'hff; // R4
                cnt_hi   = hi_ovf ? s_q.rld[15:8]
                                  : 8'(s_q.cnt[15:8] + 8'h01); // R20
                hi_match = ~cap_mode & (cnt_hi == s_q.cc[15:8]); // R2
            end
        end
        if (low_step) begin
            lo_ovf   = s_q.cnt[7:0] == 8'hff; // R3
            cnt_lo   = lo_ovf ? s_q.rld[7:0]
                              : 8'(s_q.cnt[7:0] + 8'h01); // R14 R20
            lo_match = cnt_lo == s_q.cc[7:0]; // R1
        end
        s_d.cnt = {cnt_hi, cnt_lo};

        // Capture loads the compare register and may reload the count.
        if (capture) begin
            if (split) begin
                s_d.cc[15:8] = s_q.cnt[15:8]; // R11
            end else begin
                s_d.cc = s_q.cnt; // R11
            end
            if (s_q.cna[`TMR2CC_A_CAP_RELOAD]) begin
                s_d.cnt[15:8] = s_q.rld[15:8]; // R10
                if (!split) begin
                    s_d.cnt[7:0] = s_q.rld[7:0]; // R10
                end
            end
        end

        // Software writes to flags/control B clear flags written as zero.
        if (wr && idx == `TMR2CC_IDX_FLAGS_B) begin
            s_d.cnb = (wdata[7:0] & `TMR2CC_B_RW_MASK)
                    | (s_q.cnb & wdata[7:0] & `TMR2CC_B_FLAG_MASK); // R19
        end
        // Hardware sets after the clear, so a same-cycle event survives.
        s_d.cnb[`TMR2CC_B_LOW_CMP]  = s_d.cnb[`TMR2CC_B_LOW_CMP]
                                    | lo_match; // R1 R19
        s_d.cnb[`TMR2CC_B_CC]       = s_d.cnb[`TMR2CC_B_CC]
                                    | hi_match | capture; // R2 R19
        s_d.cnb[`TMR2CC_B_LOW_OVF]  = s_d.cnb[`TMR2CC_B_LOW_OVF]
                                    | lo_ovf; // R3 R19
        s_d.cnb[`TMR2CC_B_MAIN_OVF] = s_d.cnb[`TMR2CC_B_MAIN_OVF]
                                    | hi_ovf; // R4 R19

        // Software writes to value, reload, compare and configuration.
        if (wr) begin
            unique case (idx)
                `TMR2CC_IDX_HIGH_VALUE:  s_d.cnt[15:8] = wdata[7:0];
                `TMR2CC_IDX_HIGH_RELOAD: s_d.rld[15:8] = wdata[7:0];
                `TMR2CC_IDX_HIGH_CC:     s_d.cc[15:8]  = wdata[7:0];
                `TMR2CC_IDX_VALUE: begin
                    s_d.cnt[7:0] = wdata[7:0]; // R9
                    if (!split) begin
                        s_d.cnt[15:8] = wdata[15:8]; // R8
                    end
                end
                `TMR2CC_IDX_RELOAD: begin
                    s_d.rld[7:0] = wdata[7:0]; // R10
                    if (!split) begin
                        s_d.rld[15:8] = wdata[15:8]; // R8
                    end
                end
                `TMR2CC_IDX_CC: begin
                    s_d.cc[7:0] = wdata[7:0]; // R11
                    if (!split) begin
                        s_d.cc[15:8] = wdata[15:8]; // R8
                    end
                end
                `TMR2CC_IDX_CONFIG:    s_d.cfg = wdata[7:0];
                `TMR2CC_IDX_CONTROL_A: begin
                    s_d.cna = wdata[7:0] & `TMR2CC_A_RW_MASK;
                end
                default:               s_d.cfg = s_q.cfg;
            endcase
        end

        // Waveforms toggle on match or overflow of their source timer, but not when both come in one cycle.
        if (hi_match ^ hi_ovf) begin
            s_d.wave_a = ~s_q.wave_a;
        end
        if (split ? (lo_match ^ lo_ovf) : (hi_match ^ hi_ovf)) begin
            s_d.wave_b = ~s_q.wave_b; // R5
        end
        s_d.oe0_prev = s_q.cna[`TMR2CC_A_PRI_OE];
        s_d.oe1_prev = s_q.cnb[`TMR2CC_B_SEC_OE];
        if (s_q.cna[`TMR2CC_A_PRI_OE] && !s_q.oe0_prev) begin
            s_d.wave_a = s_q.cna[`TMR2CC_A_PRI_POL];
        end
        if (s_q.cnb[`TMR2CC_B_SEC_OE] && !s_q.oe1_prev) begin
            s_d.wave_b = s_q.cnb[`TMR2CC_B_SEC_POL]; // R5 R6
        end

        // Pins show the waveform when enabled, else the port latch.
        s_d.pin_p = s_q.cna[`TMR2CC_A_PRI_OE] ? s_d.wave_a
                                              : primary_port_latch; // R17
        s_d.pin_b = s_q.cnb[`TMR2CC_B_SEC_OE] ? s_d.wave_b
                                              : alternate_port_latch; // R17

        // Interrupt requests gated by their enables.
        s_d.irq_main = s_q.cna[`TMR2CC_A_MAIN_IE]
                     & (s_d.cnb[`TMR2CC_B_MAIN_OVF] | s_d.cnb[`TMR2CC_B_CC]);
        s_d.irq_low  = s_q.cnb[`TMR2CC_B_LOW_IE]
                     & (s_d.cnb[`TMR2CC_B_LOW_OVF]
                     | s_d.cnb[`TMR2CC_B_LOW_CMP]); // R7
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q      <= '0;
            s_q.cnt  <= `TMR2CC_RST_WORD;
            s_q.rld  <= `TMR2CC_RST_WORD;
            s_q.cc   <= `TMR2CC_RST_WORD;
            s_q.cfg  <= `TMR2CC_RST_BYTE;
            s_q.cnb  <= `TMR2CC_RST_BYTE;
            s_q.cna  <= `TMR2CC_RST_BYTE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign apb_rsp              = s_q.rsp;
    assign primary_output_pin   = s_q.pin_p;
    assign alternate_output_pin = s_q.pin_b;
    assign main_irq             = s_q.irq_main;
    assign low_irq              = s_q.irq_low;
endmodule
`default_nettype wire

// >>> verif/tmr2cc_props.sv
// Port checker for the timer block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module tmr2cc_props (
    input wire logic                        mclk,
    input wire logic                        reset,
    input wire tmr2cc_pkg::tmr2cc_apb_req_t apb_req,
    input wire tmr2cc_pkg::tmr2cc_apb_rsp_t apb_rsp,
    input wire logic                        primary_port_latch,
    input wire logic                        alternate_port_latch,
    input wire logic                        primary_output_pin,
    input wire logic                        alternate_output_pin,
    input wire logic                        main_irq,
    input wire logic                        low_irq
);
    // ----------------
    // Register shadows
    // ----------------
    logic [5:0] idx;
    logic       wr_ok;
    logic       mapped;
    logic       split_q;
    logic       soe_q;
    logic       spol_q;
    logic       lie_q;
    logic       poe_q;

    assign idx    = apb_req.paddr[7:2];
    assign wr_ok  = apb_req.psel && apb_req.penable && apb_req.pwrite
                    && apb_rsp.pready;
    assign mapped = idx inside {6'h01, 6'h02, 6'h03, [6'h0b:6'h10]};

    always_ff @(posedge mclk) begin
        if (reset) begin
            {split_q, soe_q, spol_q, lie_q, poe_q} <= 5'h00;
        end else if (wr_ok) begin
            if (idx == 6'h0f) split_q <= apb_req.pwdata[3];
            if (idx == 6'h0b) {lie_q, soe_q, spol_q} <= apb_req.pwdata[7:5];
            if (idx == 6'h10) poe_q <= apb_req.pwdata[6];
        end
    end

    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    AST_ONE_WAIT: assert property (
        apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("pready late");
    AST_READY_PULSE: assert property (
        apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
    AST_RDATA_IDLE: assert property (
        !apb_rsp.pready |-> apb_rsp.prdata == 32'h0) else $error("prdata idle");
    AST_ERR_MAP: assert property (
        apb_rsp.pready |-> apb_rsp.pslverr == !mapped) else $error("pslverr");
    AST_SPLIT_HIGH: assert property (
        apb_rsp.pready && !apb_req.pwrite && split_q
        && idx inside {6'h0c, 6'h0d, 6'h0e} |-> apb_rsp.prdata[31:8] == 24'h0)
        else $error("split high byte");
    AST_PRI_LATCH: assert property (
        !poe_q && !$past(poe_q) && !$past(reset) && !$past(reset, 2)
        |-> primary_output_pin == $past(primary_port_latch))
        else $error("primary latch");
    AST_ALT_LATCH: assert property (
        !soe_q && !$past(soe_q) && !$past(reset) && !$past(reset, 2)
        |-> alternate_output_pin == $past(alternate_port_latch))
        else $error("alternate latch");
    AST_LOW_GATE: assert property (
        !lie_q && !$past(lie_q) |-> !low_irq) else $error("low irq ungated");
    AST_POL_START: assert property (
        $rose(soe_q) |-> ##[1:3] alternate_output_pin == spol_q)
        else $error("start level");

    cover property (wr_ok && idx == 6'h0b);
    cover property ($rose(low_irq));
    cover property (apb_rsp.pslverr);
    cover property ($rose(main_irq));
endmodule

bind tmr2cc_top tmr2cc_props i_props (
    .mclk(mclk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .primary_port_latch(primary_port_latch),
    .alternate_port_latch(alternate_port_latch),
    .primary_output_pin(primary_output_pin),
    .alternate_output_pin(alternate_output_pin),
    .main_irq(main_irq), .low_irq(low_irq));
`default_nettype wire

// >>> verif/tmr2cc_far.sv
// Model of the external edge source that feeds the timer's edge input.
`timescale 1ns/1ps
`default_nettype none
module tmr2cc_far (
    input  wire logic mclk,
    output var logic  edge_input
);
    initial edge_input = 1'b0;

    // Sends n pulses, each high for w clocks and low for w+1 (w of 1 is the quickest).
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            @(posedge mclk);
            edge_input <= 1'b1;
            repeat (w) @(posedge mclk);
            edge_input <= 1'b0;
            repeat (w) @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_timer_two_capture_compare.sv
// Self-checking bench for the timer block.
`timescale 1ns/1ps
`default_nettype none
module tb_timer_two_capture_compare;
    logic                        mclk = 1'b0;
    logic                        reset = 1'b1;
    tmr2cc_pkg::tmr2cc_apb_req_t apb_req = '0;
    tmr2cc_pkg::tmr2cc_apb_rsp_t apb_rsp;
    logic                        edge_input;
    logic                        pri_latch = 1'b0;
    logic                        alt_latch = 1'b0;
    logic                        pri_pin;
    logic                        alt_pin;
    logic                        main_irq;
    logic                        low_irq;
    logic [32:0]                 exp_q[$];
    logic [15:0]                 rnd;
    logic [5:0]                  regs[9] = '{6'h01, 6'h02, 6'h03, 6'h0b,
                                             6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10};
    int                          mismatches = 0;
    int                          n_checks = 0;

    always #50 mclk = ~mclk;

    tmr2cc_top i_dut (.mclk(mclk), .reset(reset), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .edge_input(edge_input),
        .primary_port_latch(pri_latch), .alternate_port_latch(alt_latch),
        .primary_output_pin(pri_pin), .alternate_output_pin(alt_pin),
        .main_irq(main_irq), .low_irq(low_irq));
    tmr2cc_far i_far (.mclk(mclk), .edge_input(edge_input));

    // ---------------
    // Tasks
    // ---------------
    task automatic chk(input logic [32:0] got, input logic [32:0] want);
        n_checks++;
        if (got !== want) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, w, {a, 2'b00}, d};
        pri_latch <= 1'($urandom);
        alt_latch <= 1'($urandom);
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic e);
        exp_q.push_back({d, e});
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Compares each read answer with the oldest noted expectation.
    always @(posedge mclk) begin
        if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1
            && !apb_req.pwrite) begin
            chk({apb_rsp.prdata, apb_rsp.pslverr}, exp_q.pop_front());
        end
    end

    initial begin
        #3_000_000;
        mismatches++;
        summarize();
    end

    // ---------------
    // Main sequence
    // ---------------
    initial begin
        void'($urandom(32'ha7f48929));
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        foreach (regs[i]) rd(regs[i], 32'h0, 1'b0);
        rd(6'h20, 32'h0, 1'b1);
        rnd = 16'($urandom);
        wr(6'h0c, 32'h1234);
        wr(6'h0d, {16'h0, rnd});
        wr(6'h0e, 32'h5678);
        rd(6'h0c, 32'h1234, 1'b0);
        rd(6'h0d, {16'h0, rnd}, 1'b0);
        rd(6'h0e, 32'h5678, 1'b0);
        wr(6'h0f, 32'h08);
        wr(6'h0c, 32'hffab);
        rd(6'h0c, 32'h00ab, 1'b0);
        rd(6'h01, 32'h12, 1'b0);
        rd(6'h0d, {24'h0, rnd[7:0]}, 1'b0);
        wr(6'h0f, 32'h00);
        rd(6'h0c, 32'h12ab, 1'b0);
        wr(6'h0d, 32'hffff);
        wr(6'h0c, 32'hfffe);
        wr(6'h0e, 32'h0001);
        wr(6'h10, 32'h08);
        wr(6'h10, 32'h00);
        rd(6'h0c, 32'hffff, 1'b0);
        rd(6'h0b, 32'h08, 1'b0);
        wr(6'h10, 32'h80);
        @(posedge mclk);
        chk({32'h0, main_irq}, 33'h1);
        wr(6'h0b, 32'h0f);
        repeat (20) @(posedge mclk);
        rd(6'h0b, 32'h08, 1'b0);
        rd(6'h0c, 32'hffff, 1'b0);
        wr(6'h0b, 32'h00);
        rd(6'h0b, 32'h00, 1'b0);
        chk({32'h0, main_irq}, 33'h0);
        wr(6'h0f, 32'h0b);
        wr(6'h0d, 32'hfe);
        wr(6'h0e, 32'hff);
        wr(6'h0c, 32'hfe);
        wr(6'h10, 32'h10);
        wr(6'h10, 32'h00);
        rd(6'h0b, 32'h05, 1'b0);
        wr(6'h0b, 32'h85);
        repeat (3) @(posedge mclk);
        chk({32'h0, low_irq}, 33'h1);
        wr(6'h0b, 32'h80);
        repeat (3) @(posedge mclk);
        chk({32'h0, low_irq}, 33'h0);
        for (int c = 1; c < 4; c++) begin
            wr(6'h0f, 32'(c << 1));
            wr(6'h0c, 32'h0100 * c);
            wr(6'h0b, 32'h00);
            wr(6'h10, 32'h08);
            i_far.pulses(1, 3);
            repeat (4) @(posedge mclk);
            wr(6'h10, 32'h00);
            rd(6'h0e, 32'h0100 * c + ((c == 1) ? 5 : 8), 1'b0);
            rd(6'h0b, 32'h02, 1'b0);
        end
        for (int c = 0; c < 3; c++) begin
            wr(6'h0f, 32'(c << 1) | 32'h1);
            wr(6'h0c, 32'h0010);
            wr(6'h10, 32'h08);
            i_far.pulses(3, 2 + c);
            repeat (4) @(posedge mclk);
            wr(6'h10, 32'h00);
            rd(6'h0c, (c == 0) ? 32'h10 : 32'h13, 1'b0);
        end
        wr(6'h0f, 32'h30);
        wr(6'h0c, 32'h0000);
        wr(6'h10, 32'h08);
        repeat (60) @(posedge mclk);
        wr(6'h10, 32'h00);
        rd(6'h0c, 32'h0008, 1'b0);
        wr(6'h0f, 32'h00);
        wr(6'h0b, 32'h20);
        repeat (3) @(posedge mclk);
        wr(6'h0b, 32'h60);
        repeat (3) @(posedge mclk);
        chk({32'h0, alt_pin}, 33'h1);
        wr(6'h0b, 32'h40);
        repeat (3) @(posedge mclk);
        chk({32'h0, alt_pin}, 33'h1);
        wr(6'h0b, 32'h00);
        wr(6'h0b, 32'h40);
        repeat (3) @(posedge mclk);
        chk({32'h0, alt_pin}, 33'h0);
        wr(6'h10, 32'h60);
        repeat (3) @(posedge mclk);
        chk({32'h0, pri_pin}, 33'h1);
        repeat (5) @(posedge mclk);
        summarize();
    end
endmodule
`default_nettype wire
